// ==== verification/cid_decoder_properties.sv ====
`timescale 1ns/1ps
module cid_decoder_checker (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire cid_pkg::cid_level_e mode_level,
  input wire cid_pkg::cid_dec_s dec_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_arith_taken;
    $past(arst_n && instr_valid && instr_word[31:26] == 6'h00 && instr_word[5:3] == 3'h4);
  endsequence
  sequence s_arith_out;
    dec_out.cls == cid_pkg::CID_CLS_REG_OP && !dec_out.reserved && dec_out.sub_code == $past(instr_word[5:0]);
  endsequence
  sequence s_reg_immediate_class_taken;
    $past(arst_n && instr_valid && instr_word[31:26] == 6'h01 && instr_word[20:16] == 5'h00);
  endsequence
  a_opcode_field: assert property ($past(arst_n) |-> dec_out.opcode == $past(instr_word[31:26]))
    else $error("opcode field wrong");
  a_jump_target: assert property ($past(arst_n) |-> dec_out.jump_target == {$past(instr_word[25:0]), 2'b00})
    else $error("jump target wrong");
  a_reg_fields: assert property ($past(arst_n) |-> {dec_out.source_reg_field, dec_out.target_reg_field,
    dec_out.dest_reg_field} == $past(instr_word[25:11]))
    else $error("register fields wrong");
  a_shift_func: assert property ($past(arst_n) |-> {dec_out.shift_amount_field,
    dec_out.function_field} == $past(instr_word[10:0]))
    else $error("shift or function wrong");
  a_imm_sign: assert property ($past(arst_n) |-> dec_out.simm == {{16{$past(instr_word[15])}}, $past(instr_word[15:0])})
    else $error("immediate wrong");
  a_valid_paired: assert property ($past(arst_n) |-> dec_out.valid == $past(instr_valid))
    else $error("valid not paired");
  a_reserved_gated: assert property (dec_out.reserved |-> dec_out.valid && dec_out.cls == cid_pkg::CID_CLS_NONE)
    else $error("reserved without valid");
  a_arith_row: assert property (s_arith_taken |-> s_arith_out)
    else $error("arith row misdecoded");
  a_reg_immediate_class_class: assert property (s_reg_immediate_class_taken |-> dec_out.cls == cid_pkg::CID_CLS_REG_IMMEDIATE)
    else $error("reg-immediate class wrong");
  a_jump_fmt: assert property ($past(arst_n && instr_word[31:27] == 5'h01) |->
    dec_out.fmt == cid_pkg::CID_FMT_JUMP)
    else $error("jump format wrong");
  a_cond_move: assert property ($past(arst_n && instr_word[31:26] == 6'h00 && instr_word[5:0] == 6'h01) |->
    dec_out.cls != cid_pkg::CID_CLS_REG_OP)
    else $error("conditional move taken as integer op");
endmodule
bind cid_decoder cid_decoder_checker u_chk (.core_clk(core_clk), .arst_n(arst_n), .instr_valid(instr_valid),
  .instr_word(instr_word), .mode_level(mode_level), .dec_out(dec_out));

// ==== verification/cid_fetch_model.sv ====
`timescale 1ns/1ps
module cid_fetch_model (
  input wire logic core_clk,
  input wire logic send,
  input wire logic [31:0] word,
  output logic instr_valid,
  output logic [31:0] instr_word
);
  logic [31:0] idle_reg = 32'h0;
  // Idle bus inverts each cycle, so an idle word never equals the word on the bus the cycle before
  always @(posedge core_clk)
  begin
    idle_reg <= send ? ~word : ~idle_reg;
  end
  assign instr_valid = send;
  assign instr_word = send ? word : idle_reg;
endmodule

// ==== verification/cpu_instruction_decoder_test.sv ====
`timescale 1ns/1ps
module cpu_instruction_decoder_test;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic send = 1'b0;
  logic [31:0] word = 32'h0;
  logic instr_valid;
  logic [31:0] instr_word;
  cid_pkg::cid_level_e mode_level = cid_pkg::CID_LEVEL_1;
  cid_pkg::cid_dec_s dec_out;
  int mismatches = 0;
  int n_tests = 0;
  always #12.5 core_clk = ~core_clk;
  cid_fetch_model fetch (.core_clk(core_clk), .send(send), .word(word), .instr_valid(instr_valid),
    .instr_word(instr_word));
  cid_decoder DUT (.core_clk(core_clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .mode_level(mode_level), .dec_out(dec_out));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input logic [31:0] w, input cid_pkg::cid_level_e lv, input logic v);
    send = v;
    word = w;
    mode_level = lv;
    @(posedge core_clk);
    #1;
  endtask
  task automatic lvl(input logic [31:0] w, input cid_pkg::cid_level_e lv, input logic rsv,
    input cid_pkg::cid_class_e cls);
    step(w, lv, 1'b1);
    chk(dec_out.reserved, rsv);
    if (rsv || cls != cid_pkg::CID_CLS_PRIMARY)
      chk(dec_out.cls, rsv ? cid_pkg::CID_CLS_NONE : cls);
  endtask
  task automatic t_fields;
    step(32'h0bff_fffd, cid_pkg::CID_LEVEL_1, 1'b1);
    chk(dec_out.jump_target, 28'hfff_fff4);
    chk(dec_out.opcode, 6'h02);
    chk(dec_out.fmt, cid_pkg::CID_FMT_JUMP);
    step(32'h8c85_8004, cid_pkg::CID_LEVEL_1, 1'b1);
    chk(dec_out.simm, 32'hffff_8004);
    chk(dec_out.fmt, cid_pkg::CID_FMT_IMM);
    step(32'h00e6_2a82, cid_pkg::CID_LEVEL_1, 1'b1);
    chk({dec_out.source_reg_field, dec_out.target_reg_field, dec_out.dest_reg_field}, 15'h1cc5);
    chk({dec_out.shift_amount_field, dec_out.function_field}, 11'h282);
    chk(dec_out.fmt, cid_pkg::CID_FMT_REG);
    step(32'h0411_0000, cid_pkg::CID_LEVEL_1, 1'b1);
    chk({dec_out.fmt, dec_out.sub_code}, {cid_pkg::CID_FMT_REG_IMMEDIATE_CLASS, 6'h11});
  endtask
  task automatic t_reset;
    step(32'h0085_1020, cid_pkg::CID_LEVEL_1, 1'b1);
    arst_n = 1'b0;
    #1;
    chk({dec_out.valid, dec_out.reserved, dec_out.cls, dec_out.opcode, dec_out.sub_code}, 64'h0);
    @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    step(32'h0085_1020, cid_pkg::CID_LEVEL_1, 1'b1);
    chk({dec_out.valid, dec_out.cls, dec_out.sub_code, dec_out.reserved},
      {1'b1, cid_pkg::CID_CLS_REG_OP, 6'h20, 1'b0});
  endtask
  task automatic t_arith;
    for (int f = 0; f < 8; f++)
    begin
      step(32'h0085_1020 | 32'(f), cid_pkg::CID_LEVEL_1, 1'b1);
      chk({dec_out.cls, dec_out.sub_code, dec_out.reserved}, {cid_pkg::CID_CLS_REG_OP, 6'(8'h20 + f), 1'b0});
    end
  endtask
  task automatic t_levels;
    lvl(32'h0400_0000, cid_pkg::CID_LEVEL_1, 1'b0, cid_pkg::CID_CLS_REG_IMMEDIATE);
    lvl(32'h0411_0000, cid_pkg::CID_LEVEL_1, 1'b0, cid_pkg::CID_CLS_REG_IMMEDIATE);
    lvl(32'h0408_0000, cid_pkg::CID_LEVEL_1, 1'b1, cid_pkg::CID_CLS_NONE);
    lvl(32'h0408_0000, cid_pkg::CID_LEVEL_2, 1'b0, cid_pkg::CID_CLS_REG_IMMEDIATE);
    lvl(32'h5000_0000, cid_pkg::CID_LEVEL_1, 1'b1, cid_pkg::CID_CLS_NONE);
    lvl(32'h5c00_0000, cid_pkg::CID_LEVEL_2, 1'b0, cid_pkg::CID_CLS_PRIMARY);
    lvl(32'hc000_0000, cid_pkg::CID_LEVEL_1, 1'b1, cid_pkg::CID_CLS_NONE);
    lvl(32'he000_0000, cid_pkg::CID_LEVEL_2, 1'b0, cid_pkg::CID_CLS_PRIMARY);
    lvl(32'h0000_000f, cid_pkg::CID_LEVEL_1, 1'b1, cid_pkg::CID_CLS_NONE);
    lvl(32'h0000_0030, cid_pkg::CID_LEVEL_2, 1'b0, cid_pkg::CID_CLS_REG_OP);
    lvl(32'h6000_0000, cid_pkg::CID_LEVEL_2, 1'b1, cid_pkg::CID_CLS_NONE);
    lvl(32'h6000_0000, cid_pkg::CID_LEVEL_3, 1'b0, cid_pkg::CID_CLS_PRIMARY);
    lvl(32'h4c00_0000, cid_pkg::CID_LEVEL_2, 1'b1, cid_pkg::CID_CLS_NONE);
    lvl(32'hcc00_0000, cid_pkg::CID_LEVEL_3, 1'b1, cid_pkg::CID_CLS_NONE);
    lvl(32'h4c00_0000, cid_pkg::CID_LEVEL_4, 1'b0, cid_pkg::CID_CLS_FPU_EXTENDED);
    lvl(32'h0000_0001, cid_pkg::CID_LEVEL_4, 1'b0, cid_pkg::CID_CLS_FPU_COND_MOVE);
    lvl(32'h4000_0000, cid_pkg::CID_LEVEL_1, 1'b0, cid_pkg::CID_CLS_SYSTEM_COPROC);
    lvl(32'ha000_0000, cid_pkg::CID_LEVEL_1, 1'b0, cid_pkg::CID_CLS_PRIMARY);
    lvl(32'h9c00_0000, cid_pkg::CID_LEVEL_1, 1'b1, cid_pkg::CID_CLS_NONE);
  endtask
  task automatic t_idle;
    step(32'h6000_0000, cid_pkg::CID_LEVEL_1, 1'b0);
    chk({dec_out.valid, dec_out.reserved}, 2'b00);
    step(32'h0000_0000, cid_pkg::CID_LEVEL_1, 1'b0);
    chk(dec_out.valid, 1'b0);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #(25 * 2000);
    mismatches++;
    finish_test();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    t_fields();
    t_arith();
    t_levels();
    t_idle();
    t_reset();
    finish_test();
  end
endmodule

// ==== verilog/cid_decoder.sv ====
`timescale 1ns/1ps
module cid_decoder #(
  parameter cid_pkg::cid_level_e IMPL_LEVEL = cid_pkg::CID_LEVEL_4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire cid_pkg::cid_level_e mode_level,
  output cid_pkg::cid_dec_s dec_out
);

  cid_pkg::cid_state_s state_reg;
  cid_pkg::cid_state_s state_next;
  cid_pkg::cid_level_e lvl;
  logic [5:0] op;
  logic [5:0] fn;
  logic [4:0] tf;
  logic ok;
  logic lvl2;
  logic lvl3;
  logic lvl4;
  logic fn_def;
  cid_pkg::cid_level_e fn_min;

  // Active level is the lower of the implemented one and the selected mode
  always_comb
  begin
    lvl = (mode_level > IMPL_LEVEL) ? IMPL_LEVEL : mode_level;
  end

  assign lvl2 = (lvl >= cid_pkg::CID_LEVEL_2);
  assign lvl3 = (lvl >= cid_pkg::CID_LEVEL_3);
  assign lvl4 = (lvl == cid_pkg::CID_LEVEL_4);

  assign op = instr_word[cid_pkg::OP_HI:cid_pkg::OP_LO];
  assign fn = instr_word[cid_pkg::FUNC_HI:cid_pkg::FUNC_LO];
  assign tf = instr_word[cid_pkg::TGT_HI:cid_pkg::TGT_LO];

  // Function-field table: entry present and the lowest level defining it
  always_comb
  begin
    fn_def = 1'b1;
    fn_min = cid_pkg::CID_LEVEL_1;
    case (fn[5:3])
      3'h0:
      begin
        case (fn[2:0])
          3'h0: fn_min = cid_pkg::CID_LEVEL_1;
          3'h1: fn_min = cid_pkg::CID_LEVEL_4;
          3'h2: fn_min = cid_pkg::CID_LEVEL_1;
          3'h3: fn_min = cid_pkg::CID_LEVEL_1;
          3'h4: fn_min = cid_pkg::CID_LEVEL_1;
          3'h5: fn_def = 1'b0;
          3'h6: fn_min = cid_pkg::CID_LEVEL_1;
          default: fn_min = cid_pkg::CID_LEVEL_1;
        endcase
      end
      3'h1:
      begin
        case (fn[2:0])
          3'h0: fn_min = cid_pkg::CID_LEVEL_1;
          3'h1: fn_min = cid_pkg::CID_LEVEL_1;
          3'h2: fn_min = cid_pkg::CID_LEVEL_4;
          3'h3: fn_min = cid_pkg::CID_LEVEL_4;
          3'h4: fn_min = cid_pkg::CID_LEVEL_1;
          3'h5: fn_min = cid_pkg::CID_LEVEL_1;
          3'h6: fn_def = 1'b0;
          default: fn_min = cid_pkg::CID_LEVEL_2;
        endcase
      end
      3'h2:
      begin
        case (fn[2:0])
          3'h0: fn_min = cid_pkg::CID_LEVEL_1;
          3'h1: fn_min = cid_pkg::CID_LEVEL_1;
          3'h2: fn_min = cid_pkg::CID_LEVEL_1;
          3'h3: fn_min = cid_pkg::CID_LEVEL_1;
          3'h4: fn_min = cid_pkg::CID_LEVEL_3;
          3'h5: fn_def = 1'b0;
          3'h6: fn_min = cid_pkg::CID_LEVEL_3;
          default: fn_min = cid_pkg::CID_LEVEL_3;
        endcase
      end
      3'h3:
      begin
        case (fn[2:0])
          3'h0: fn_min = cid_pkg::CID_LEVEL_1;
          3'h1: fn_min = cid_pkg::CID_LEVEL_1;
          3'h2: fn_min = cid_pkg::CID_LEVEL_1;
          3'h3: fn_min = cid_pkg::CID_LEVEL_1;
          3'h4: fn_min = cid_pkg::CID_LEVEL_3;
          3'h5: fn_min = cid_pkg::CID_LEVEL_3;
          3'h6: fn_min = cid_pkg::CID_LEVEL_3;
          default: fn_min = cid_pkg::CID_LEVEL_3;
        endcase
      end
      3'h4:
      begin
        case (fn[2:0])
          3'h0: fn_min = cid_pkg::CID_LEVEL_1;
          3'h1: fn_min = cid_pkg::CID_LEVEL_1;
          3'h2: fn_min = cid_pkg::CID_LEVEL_1;
          3'h3: fn_min = cid_pkg::CID_LEVEL_1;
          3'h4: fn_min = cid_pkg::CID_LEVEL_1;
          3'h5: fn_min = cid_pkg::CID_LEVEL_1;
          3'h6: fn_min = cid_pkg::CID_LEVEL_1;
          default: fn_min = cid_pkg::CID_LEVEL_1;
        endcase
      end
      3'h5:
      begin
        case (fn[2:0])
          3'h0: fn_def = 1'b0;
          3'h1: fn_def = 1'b0;
          3'h2: fn_min = cid_pkg::CID_LEVEL_1;
          3'h3: fn_min = cid_pkg::CID_LEVEL_1;
          3'h4: fn_min = cid_pkg::CID_LEVEL_3;
          3'h5: fn_min = cid_pkg::CID_LEVEL_3;
          3'h6: fn_min = cid_pkg::CID_LEVEL_3;
          default: fn_min = cid_pkg::CID_LEVEL_3;
        endcase
      end
      3'h6:
      begin
        case (fn[2:0])
          3'h0: fn_min = cid_pkg::CID_LEVEL_2;
          3'h1: fn_min = cid_pkg::CID_LEVEL_2;
          3'h2: fn_min = cid_pkg::CID_LEVEL_2;
          3'h3: fn_min = cid_pkg::CID_LEVEL_2;
          3'h4: fn_min = cid_pkg::CID_LEVEL_2;
          3'h5: fn_def = 1'b0;
          3'h6: fn_min = cid_pkg::CID_LEVEL_2;
          default: fn_def = 1'b0;
        endcase
      end
      3'h7:
      begin
        case (fn[2:0])
          3'h0: fn_min = cid_pkg::CID_LEVEL_3;
          3'h1: fn_def = 1'b0;
          3'h2: fn_min = cid_pkg::CID_LEVEL_3;
          3'h3: fn_min = cid_pkg::CID_LEVEL_3;
          3'h4: fn_min = cid_pkg::CID_LEVEL_3;
          3'h5: fn_def = 1'b0;
          3'h6: fn_min = cid_pkg::CID_LEVEL_3;
          default: fn_min = cid_pkg::CID_LEVEL_3;
        endcase
      end
      default: fn_def = 1'b0;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    ok = 1'b0;
    state_next.out.valid = instr_valid;
    state_next.out.opcode = op;
    state_next.out.source_reg_field = instr_word[cid_pkg::SRC_HI:cid_pkg::SRC_LO];
    state_next.out.target_reg_field = tf;
    state_next.out.dest_reg_field = instr_word[cid_pkg::DST_HI:cid_pkg::DST_LO];
    state_next.out.shift_amount_field = instr_word[cid_pkg::SHAMT_HI:cid_pkg::SHAMT_LO];
    state_next.out.function_field = fn;
    state_next.out.simm = {{16{instr_word[cid_pkg::IMM_HI]}},
                           instr_word[cid_pkg::IMM_HI:cid_pkg::IMM_LO]};
    state_next.out.jump_target = {instr_word[cid_pkg::JIDX_HI:cid_pkg::JIDX_LO],
                                  2'b00};
    state_next.out.sub_code = op;
    state_next.out.fmt = cid_pkg::CID_FMT_IMM;
    state_next.out.cls = cid_pkg::CID_CLS_PRIMARY;
    // Opcode row then column
    case (op[5:3])
      3'h0:
      begin
        case (op[2:0])
          3'h0:
          begin
            // Register class by function row and column
            state_next.out.fmt = cid_pkg::CID_FMT_REG;
            state_next.out.cls = cid_pkg::CID_CLS_REG_OP;
            state_next.out.sub_code = fn;
            ok = fn_def && (lvl >= fn_min);
            if (fn == cid_pkg::FN_FPU_COND_MOVE)
            begin
              state_next.out.cls = cid_pkg::CID_CLS_FPU_COND_MOVE;
              ok = lvl4;
            end
          end
          3'h1:
          begin
            // Register-immediate class by target field
            state_next.out.fmt = cid_pkg::CID_FMT_REG_IMMEDIATE_CLASS;
            state_next.out.cls = cid_pkg::CID_CLS_REG_IMMEDIATE;
            state_next.out.sub_code = {1'b0, tf};
            case (tf[4:3])
              2'h0, 2'h2: ok = (tf[2:0] <= 3'h1) || (lvl2 && tf[2:0] <= 3'h3);
              2'h1: ok = lvl2 && (tf[2:0] != 3'h5) && (tf[2:0] != 3'h7);
              default: ok = 1'b0;
            endcase
          end
          3'h2, 3'h3:
          begin
            state_next.out.fmt = cid_pkg::CID_FMT_JUMP;
            ok = 1'b1;
          end
          default: ok = 1'b1;
        endcase
      end
      3'h1: ok = 1'b1;
      3'h2:
      begin
        if (op[2])
        begin
          ok = lvl2;
        end
        else
        begin
          state_next.out.fmt = cid_pkg::CID_FMT_COPROC;
          case (op[1:0])
            2'h0:
            begin
              state_next.out.cls = cid_pkg::CID_CLS_SYSTEM_COPROC;
              ok = 1'b1;
            end
            2'h1:
            begin
              state_next.out.cls = cid_pkg::CID_CLS_FPU;
              ok = 1'b1;
            end
            2'h2:
            begin
              state_next.out.cls = cid_pkg::CID_CLS_COPROC2;
              ok = 1'b1;
            end
            default:
            begin
              // Spare coprocessor below level four, extended fpu at four
              if (lvl4)
              begin
                state_next.out.cls = cid_pkg::CID_CLS_FPU_EXTENDED;
                ok = 1'b1;
              end
              else
              begin
                state_next.out.cls = cid_pkg::CID_CLS_SPARE_COPROC;
                ok = (IMPL_LEVEL <= cid_pkg::CID_LEVEL_2);
              end
            end
          endcase
        end
      end
      3'h3: ok = lvl3 && (op[2:0] <= 3'h3);
      3'h4: ok = (op[2:0] != 3'h7) || lvl3;
      3'h5: ok = (op[2:0] <= 3'h3) || (op[2:0] == 3'h6) || (lvl2 && op[2:0] == 3'h7)
                 || (lvl3 && (op[2:0] == 3'h4 || op[2:0] == 3'h5));
      default:
      begin
        // Rows 110 and 111: linked access, coprocessor and doubleword memory
        case (op[2:0])
          3'h0: ok = lvl2;
          3'h1, 3'h2:
          begin
            state_next.out.cls = cid_pkg::CID_CLS_COPROC_MEM;
            ok = 1'b1;
          end
          3'h3:
          begin
            if (lvl4 && op == cid_pkg::OP_PREFETCH)
            begin
              ok = 1'b1;
            end
            else
            begin
              state_next.out.cls = cid_pkg::CID_CLS_SPARE_COPROC;
              ok = (IMPL_LEVEL <= cid_pkg::CID_LEVEL_2);
            end
          end
          3'h4: ok = lvl3;
          3'h5, 3'h6:
          begin
            state_next.out.cls = cid_pkg::CID_CLS_COPROC_MEM;
            ok = lvl2;
          end
          default:
          begin
            if (lvl3)
            begin
              ok = 1'b1;
            end
            else
            begin
              state_next.out.cls = cid_pkg::CID_CLS_SPARE_COPROC;
              ok = lvl2 && (IMPL_LEVEL <= cid_pkg::CID_LEVEL_2);
            end
          end
        endcase
      end
    endcase
    state_next.out.reserved = instr_valid && !ok;
    if (!ok)
    begin
      state_next.out.cls = cid_pkg::CID_CLS_NONE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign dec_out = state_reg.out;

endmodule

// ==== verilog/cid_pkg.sv ====
package cid_pkg;

  // Word layout
  localparam int WORD_W = 32;
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int SRC_HI = 25;
  localparam int SRC_LO = 21;
  localparam int TGT_HI = 20;
  localparam int TGT_LO = 16;
  localparam int DST_HI = 15;
  localparam int DST_LO = 11;
  localparam int SHAMT_HI = 10;
  localparam int SHAMT_LO = 6;
  localparam int FUNC_HI = 5;
  localparam int FUNC_LO = 0;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 0;
  localparam int JIDX_HI = 25;
  localparam int JIDX_LO = 0;
  localparam int JTGT_W = 28;
  localparam int JIDX_SHIFT = 2;

  // Architecture levels and restriction modes
  typedef enum logic [1:0] {
    CID_LEVEL_1,
    CID_LEVEL_2,
    CID_LEVEL_3,
    CID_LEVEL_4
  } cid_level_e;

  // Primary opcode values
  localparam logic [5:0] OP_REG_CLASS = 6'h00;
  localparam logic [5:0] OP_REG_IMMEDIATE_CLASS = 6'h01;
  localparam logic [5:0] OP_SYSTEM_COPROC_CLASS = 6'h10;
  localparam logic [5:0] OP_FPU_CLASS = 6'h11;
  localparam logic [5:0] OP_COPROC2_CLASS = 6'h12;
  localparam logic [5:0] OP_SPARE_FPU_EXT = 6'h13;
  localparam logic [5:0] OP_LOAD_LINKED = 6'h30;
  localparam logic [5:0] OP_STORE_CONDITIONAL = 6'h38;
  localparam logic [5:0] OP_PREFETCH = 6'h33;

  // Register class function values
  localparam logic [5:0] FN_FPU_COND_MOVE = 6'h01;
  localparam logic [5:0] FN_BARRIER = 6'h0f;

  typedef enum logic [2:0] {
    CID_FMT_IMM,
    CID_FMT_JUMP,
    CID_FMT_REG,
    CID_FMT_REG_IMMEDIATE_CLASS,
    CID_FMT_COPROC
  } cid_fmt_e;

  // Decoded identity: class of the word plus the selecting code
  typedef enum logic [3:0] {
    CID_CLS_NONE,
    CID_CLS_PRIMARY,
    CID_CLS_REG_OP,
    CID_CLS_REG_IMMEDIATE,
    CID_CLS_SYSTEM_COPROC,
    CID_CLS_FPU,
    CID_CLS_FPU_EXTENDED,
    CID_CLS_FPU_COND_MOVE,
    CID_CLS_COPROC2,
    CID_CLS_SPARE_COPROC,
    CID_CLS_COPROC_MEM
  } cid_class_e;

  typedef struct packed {
    logic valid;
    logic reserved;
    cid_fmt_e fmt;
    cid_class_e cls;
    logic [5:0] opcode;
    logic [5:0] sub_code;
    logic [4:0] source_reg_field;
    logic [4:0] target_reg_field;
    logic [4:0] dest_reg_field;
    logic [4:0] shift_amount_field;
    logic [5:0] function_field;
    logic [31:0] simm;
    logic [27:0] jump_target;
  } cid_dec_s;

  typedef struct packed {
    cid_dec_s out;
  } cid_state_s;

endpackage
